//--- rtl/bcdtd_pkg.sv
// Package for the BCD time and date counter bank.
// Assumes a single core clock domain; all users refer to names by scope.
package bcdtd_pkg;

    // Register addresses of the counter bank and the first control register.
    localparam logic [3:0] ADDR_CONTROL_1 = 4'h0;
    localparam logic [3:0] ADDR_SECONDS   = 4'h2;
    localparam logic [3:0] ADDR_MINUTES   = 4'h3;
    localparam logic [3:0] ADDR_HOURS     = 4'h4;
    localparam logic [3:0] ADDR_DAYS      = 4'h5;
    localparam logic [3:0] ADDR_WEEKDAY   = 4'h6;
    localparam logic [3:0] ADDR_MONTH     = 4'h7;
    localparam logic [3:0] ADDR_YEAR      = 4'h8;

    // Field positions.
    localparam int RESET_FLAG_BIT  = 7;
    localparam int AFTERNOON_BIT   = 5;
    localparam int HOUR_FORMAT_BIT = 2;
    localparam int HALT_BIT        = 5;

    // Values after reset.
    localparam logic [6:0] SECONDS_RST = 7'h00;
    localparam logic [6:0] MINUTES_RST = 7'h00;
    localparam logic [5:0] HOURS_RST   = 6'h00;
    localparam logic [5:0] DAYS_RST    = 6'h01;
    localparam logic [2:0] WEEKDAY_RST = 3'h0;
    localparam logic [4:0] MONTH_RST   = 5'h01;
    localparam logic [7:0] YEAR_RST    = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;

    // Tick rate and the core clock rate it is derived from.
    localparam int TICK_HZ     = 1;
    localparam int CORE_CLK_HZ = 100000000;
    localparam int TICK_CYCLES = CORE_CLK_HZ / TICK_HZ;

    // One register access from the host port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bcdtd_req_t;

    // The whole time and date state.
    typedef struct packed {
        logic       reset_occurred_flag;
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic [5:0] hours;
        logic [5:0] days;
        logic [2:0] weekday;
        logic [4:0] month;
        logic [7:0] year;
    } bcdtd_time_t;

endpackage : bcdtd_pkg

//--- rtl/bcdtd_bcd_digit.sv
// One BCD two-digit counter with a programmable wrap.
// Assumes the caller supplies the low and high limits as BCD values.
`timescale 1ns/1ns
`default_nettype none
module bcdtd_bcd_digit #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] low_limit,
    input  wire logic [W-1:0] high_limit,
    output logic      [W-1:0] next_value,
    output logic              wrap
);
    initial begin
        if (W < 5 || W > 8) begin
            $error("bcdtd_bcd_digit width must lie between 5 and 8");
        end
    end

    // Increment in BCD; a units digit of 9 or more carries to the tens.
    always_comb begin
        logic [3:0] units;
        logic [3:0] tens;
        units = value[3:0];
        tens  = 4'(value[W-1:4]);
        wrap  = (value >= high_limit);
        if (wrap) begin
            next_value = low_limit;
        end else if (units >= 4'h9) begin
            next_value = W'({tens + 4'h1, 4'h0});
        end else begin
            next_value = W'({tens, units + 4'h1});
        end
    end
endmodule : bcdtd_bcd_digit
`default_nettype wire

//--- rtl/bcdtd_counters.sv
// Time of day and calendar counter bank, advanced from a 1 Hz tick.
// Assumes register accesses arrive as single-cycle strobes on core_clk.
`timescale 1ns/1ns
`default_nettype none
//
// Notes on the counter bank as a whole.
//
// Every time and date field lives in one packed struct so that the whole
// state advances in a single clock edge. A host read therefore never sees
// a half-updated time, such as new seconds paired with old minutes. The
// cost is one wide register load per tick, which is cheap at this size.
//
// The divider counts core clock cycles and raises a one-cycle tick each
// time it reaches its last count. The tick is combinational so that the
// counters advance on the very edge at which the divider wraps. Anyone
// who wants to see the tick outside the bank must sample it on that edge.
//
// Halting the divider clears it rather than freezing it. After the halt
// is lifted a full tick period elapses before the next tick, so software
// that sets the time under halt gets a whole second before it moves.
//
// Each two-digit field other than the hours uses the same small incrementer. It wraps when the
// field reaches or passes its upper limit, so a field written with a value
// above its range returns to the low limit on the next carry instead of
// counting on through undefined codes. Invalid units digits below the limit
// carry to the tens just as a units digit of 9 does, leaving units of 0.
//
// The hour field needs its own increment because the twelve hour coding
// is not a plain BCD count: twelve comes before one, and the afternoon
// indicator flips between eleven and twelve. The day carry is raised only
// at midnight, that is when eleven at night becomes twelve in the morning.
// Changing the hour format does not convert a stored hour; software must
// rewrite the hours register after switching formats.
//
// The leap test looks only at the two BCD year digits. A year is a
// multiple of four when an even tens digit meets units of 0, 4 or 8, or
// an odd tens digit meets units of 2 or 6. Year 00 counts as a leap year,
// which is right for the present century but not for every century.
//
// Host writes are applied after the tick ripple in the same cycle. A
// write to one field therefore wins over a tick for that field only, and
// every other field still advances. This keeps a write from being lost
// while a carry is in progress, at the cost of a possible odd state if
// software writes one field right on a carry boundary.
//
// Reads are registered. The read data appears one cycle after the strobe
// and then stands until the next read strobe. Unused bits always read as
// zero, and addresses outside the bank read as zero too. A read in the
// same cycle as a write returns the value before the write.
//
// The reset occurred flag is set by reset or by a written one. Software clears it by
// writing zero into the top bit of the seconds register; writing one is
// accepted as well, so software can mark the time as untrusted itself.
//
// The first control register keeps only the bits that the bank or its
// neighbours use. The others read as zero whatever was written to them.
//
// Limitations worth knowing:
//  - the divider period is a parameter; a value of one or less is refused
//    because the divider then could not form a single-cycle tick;
//  - the weekday counts 0 to 6 and wraps; a value of 7 written by software
//    steps back to 0 on the next day carry;
//  - there is no protection against a host read tearing across the
//    moment of a carry, other than the whole-state register load.
//
// Outputs:
//  - rdata holds the last read value;
//  - tick pulses for one cycle per second;
//  - hour_format_12 mirrors the format bit of the first control register.
//
// Overview of operation
// - Time and date values held as packed BCD, tens upper, units lower.
// - Seconds bit 7 set by chip reset, held until software clears it.
// - Seconds bits 6..0 hold BCD 00 to 59.
// - Minutes bits 6..0 hold BCD 00 to 59; bit 7 reads zero.
// - Twelve hour mode: bits 4..0 hold 01 to 12, bit 5 marks PM.
// - Twenty-four hour mode: bits 5..0 hold 00 to 23; bits 7,6 zero.
// - Hour coding follows the format bit in the first control register.
// - Day of month bits 5..0 hold BCD 01 to 31, upper bits zero.
// - February gets a 29th day when year divides by 4, including 00.
// - Weekday is binary 0 to 6 in bits 2..0, upper bits zero.
// - Weekday codes carry no meaning here; they only count cyclically.
// - Month bits 4..0 hold BCD 01 to 12, upper bits zero.
// - Year is eight bit BCD 00 to 99.
// - All counters advance from one 1 Hz tick.
// - Control bit 2 selects 12 hour when set, resets to 24 hour.
// - Halt bit clears the divider so no ticks reach the counters.
module bcdtd_counters #(
    parameter int TICK_CYCLES = bcdtd_pkg::TICK_CYCLES
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire bcdtd_pkg::bcdtd_req_t req,
    output logic                [7:0]  rdata,
    output logic                       tick,
    output logic                       hour_format_12
);
    localparam int DW = $clog2(TICK_CYCLES);

    initial begin
        if (TICK_CYCLES < 2) begin
            $error("TICK_CYCLES must be at least 2");
        end
    end

    bcdtd_pkg::bcdtd_time_t t_r;
    bcdtd_pkg::bcdtd_time_t t_nxt;
    logic [7:0]    ctrl_r;
    logic [7:0]    ctrl_nxt;
    logic [DW-1:0] div_r;
    logic [DW-1:0] div_nxt;
    logic [7:0]    rdata_r;
    logic [7:0]    rdata_nxt;
    logic          halted;
    logic          tick_now;

    assign halted         = ctrl_r[bcdtd_pkg::HALT_BIT];
    assign hour_format_12 = ctrl_r[bcdtd_pkg::HOUR_FORMAT_BIT];
    assign tick           = tick_now;
    assign rdata          = rdata_r;

    // Divider chain; held at zero while halted so no tick can escape.
    always_comb begin
        tick_now = 1'b0;
        if (halted) begin
            div_nxt = '0;
        end else if (div_r == DW'(TICK_CYCLES - 1)) begin
            div_nxt  = '0;
            tick_now = 1'b1;
        end else begin
            div_nxt = div_r + DW'(1);
        end
    end

    // Per-field BCD incrementers; only the day limit varies, with month and leap year.
    logic [6:0] sec_inc;
    logic [6:0] min_inc;
    logic [5:0] day_inc;
    logic [4:0] mon_inc;
    logic [7:0] yr_inc;
    logic       sec_wrap;
    logic       min_wrap;
    logic       day_wrap;
    logic       mon_wrap;
    logic [5:0] month_len;
    logic       leap;

    // Units 0, 4 or 8 with an even tens, or 2 or 6 with an odd tens, give a multiple of four.
    assign leap = t_r.year[4] ? (t_r.year[3:0] == 4'h2 ||
                                 t_r.year[3:0] == 4'h6)
                              : (t_r.year[3:0] == 4'h0 ||
                                 t_r.year[3:0] == 4'h4 ||
                                 t_r.year[3:0] == 4'h8);

    // Month length; BCD months 04, 06, 09 and 11 have thirty days.
    always_comb begin
        case (t_r.month)
            5'h02:   month_len = leap ? 6'h29 : 6'h28;
            5'h04,
            5'h06,
            5'h09,
            5'h11:   month_len = 6'h30;
            default: month_len = 6'h31;
        endcase
    end

    bcdtd_bcd_digit #(.W(7)) u_sec (
        .value      (t_r.seconds),
        .low_limit  (7'h00),
        .high_limit (7'h59),
        .next_value (sec_inc),
        .wrap       (sec_wrap)
    );

    bcdtd_bcd_digit #(.W(7)) u_min (
        .value      (t_r.minutes),
        .low_limit  (7'h00),
        .high_limit (7'h59),
        .next_value (min_inc),
        .wrap       (min_wrap)
    );

    bcdtd_bcd_digit #(.W(6)) u_day (
        .value      (t_r.days),
        .low_limit  (6'h01),
        .high_limit (month_len),
        .next_value (day_inc),
        .wrap       (day_wrap)
    );

    bcdtd_bcd_digit #(.W(5)) u_mon (
        .value      (t_r.month),
        .low_limit  (5'h01),
        .high_limit (5'h12),
        .next_value (mon_inc),
        .wrap       (mon_wrap)
    );

    bcdtd_bcd_digit #(.W(8)) u_yr (
        .value      (t_r.year),
        .low_limit  (8'h00),
        .high_limit (8'h99),
        .next_value (yr_inc),
        .wrap       ()
    );

    // Hour increment for both codings, giving the day carry at midnight.
    logic [5:0] hour_inc;
    logic       hour_wrap;
    always_comb begin
        logic [4:0] h12;
        h12       = t_r.hours[4:0];
        hour_wrap = 1'b0;
        if (hour_format_12) begin
            if (h12 == 5'h11) begin
                hour_inc  = {~t_r.hours[bcdtd_pkg::AFTERNOON_BIT], 5'h12};
                hour_wrap = t_r.hours[bcdtd_pkg::AFTERNOON_BIT];
            end else if (h12 >= 5'h12) begin
                hour_inc = {t_r.hours[bcdtd_pkg::AFTERNOON_BIT], 5'h01};
            end else if (h12[3:0] >= 4'h9) begin
                hour_inc = {t_r.hours[bcdtd_pkg::AFTERNOON_BIT],
                            h12[4] + 1'b1, 4'h0};
            end else begin
                hour_inc = {t_r.hours[bcdtd_pkg::AFTERNOON_BIT],
                            h12[4], h12[3:0] + 4'h1};
            end
        end else begin
            if (t_r.hours >= 6'h23) begin
                hour_inc  = 6'h00;
                hour_wrap = 1'b1;
            end else if (t_r.hours[3:0] >= 4'h9) begin
                hour_inc = {t_r.hours[5:4] + 2'h1, 4'h0};
            end else begin
                hour_inc = {t_r.hours[5:4], t_r.hours[3:0] + 4'h1};
            end
        end
    end

    // Ripple on tick, then let any host write override its field.
    always_comb begin
        t_nxt    = t_r;
        ctrl_nxt = ctrl_r;
        if (tick_now) begin
            t_nxt.seconds = sec_inc;
            if (sec_wrap) begin
                t_nxt.minutes = min_inc;
                if (min_wrap) begin
                    t_nxt.hours = hour_inc;
                    if (hour_wrap) begin
                        t_nxt.days    = day_inc;
                        t_nxt.weekday = (t_r.weekday >= 3'h6) ? 3'h0
                                        : t_r.weekday + 3'h1;
                        if (day_wrap) begin
                            t_nxt.month = mon_inc;
                            if (mon_wrap) begin
                                t_nxt.year = yr_inc;
                            end
                        end
                    end
                end
            end
        end
        if (req.wr) begin
            case (req.addr)
                bcdtd_pkg::ADDR_CONTROL_1: ctrl_nxt = req.wdata & 8'hac;
                bcdtd_pkg::ADDR_SECONDS: begin
                    t_nxt.reset_occurred_flag = req.wdata[7];
                    t_nxt.seconds             = req.wdata[6:0];
                end
                bcdtd_pkg::ADDR_MINUTES: t_nxt.minutes = req.wdata[6:0];
                bcdtd_pkg::ADDR_HOURS:   t_nxt.hours   = req.wdata[5:0];
                bcdtd_pkg::ADDR_DAYS:    t_nxt.days    = req.wdata[5:0];
                bcdtd_pkg::ADDR_WEEKDAY: t_nxt.weekday = req.wdata[2:0];
                bcdtd_pkg::ADDR_MONTH:   t_nxt.month   = req.wdata[4:0];
                bcdtd_pkg::ADDR_YEAR:    t_nxt.year    = req.wdata;
                default: ;
            endcase
        end
    end

    // Read data; unused upper bits always read as zero.
    always_comb begin
        rdata_nxt = rdata_r;
        if (req.rd) begin
            case (req.addr)
                bcdtd_pkg::ADDR_CONTROL_1: rdata_nxt = ctrl_r;
                bcdtd_pkg::ADDR_SECONDS:
                    rdata_nxt = {t_r.reset_occurred_flag, t_r.seconds};
                bcdtd_pkg::ADDR_MINUTES: rdata_nxt = {1'b0, t_r.minutes};
                bcdtd_pkg::ADDR_HOURS:   rdata_nxt = {2'b00, t_r.hours};
                bcdtd_pkg::ADDR_DAYS:    rdata_nxt = {2'b00, t_r.days};
                bcdtd_pkg::ADDR_WEEKDAY:
                    rdata_nxt = {5'h00, t_r.weekday};
                bcdtd_pkg::ADDR_MONTH:   rdata_nxt = {3'h0, t_r.month};
                bcdtd_pkg::ADDR_YEAR:    rdata_nxt = t_r.year;
                default:                 rdata_nxt = 8'h00;
            endcase
        end
    end

    // Reset marks the time untrustworthy and selects 24 hour coding.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            t_r.reset_occurred_flag <= 1'b1;
            t_r.seconds             <= bcdtd_pkg::SECONDS_RST;
            t_r.minutes             <= bcdtd_pkg::MINUTES_RST;
            t_r.hours               <= bcdtd_pkg::HOURS_RST;
            t_r.days                <= bcdtd_pkg::DAYS_RST;
            t_r.weekday             <= bcdtd_pkg::WEEKDAY_RST;
            t_r.month               <= bcdtd_pkg::MONTH_RST;
            t_r.year                <= bcdtd_pkg::YEAR_RST;
            ctrl_r                  <= bcdtd_pkg::CONTROL_RST;
            div_r                   <= '0;
            rdata_r                 <= 8'h00;
        end else begin
            t_r     <= t_nxt;
            ctrl_r  <= ctrl_nxt;
            div_r   <= div_nxt;
            rdata_r <= rdata_nxt;
        end
    end
endmodule : bcdtd_counters
`default_nettype wire

//--- sim/bcdtd_properties.sv
// Port checker for the time and date counter bank.
// Assumes a bind to bcdtd_counters run with TICK_CYCLES of 4.
`timescale 1ns/1ns
`default_nettype none
module bcdtd_properties #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    input wire bcdtd_pkg::bcdtd_req_t req,
    input wire logic [7:0]            rdata,
    input wire logic                  tick,
    input wire logic                  hour_format_12
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic halt_r;
    logic halt_nxt;
    logic ctl_wr;
    logic rd2;
    logic rd3;
    logic rd6;
    // Halt mirror; ticks seen while it is set mean the divider leaked.
    assign ctl_wr = req.wr && req.addr == 4'h0;
    assign rd2 = req.rd && req.addr == 4'h2;
    assign rd3 = req.rd && req.addr == 4'h3;
    assign rd6 = req.rd && req.addr == 4'h6;
    always_comb begin
        halt_nxt = ctl_wr ? req.wdata[5] : halt_r;
    end
    always_ff @(posedge core_clk) begin
        halt_r <= sys_rst ? 1'b0 : halt_nxt;
    end
    property p_fmt_rst; $fell(sys_rst) |-> !hour_format_12; endproperty
    a_fmt_rst: assert property (p_fmt_rst) else $error("format not 24h");
    property p_fmt; ctl_wr |=> hour_format_12 == $past(req.wdata[2]);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format bit lost");
    property p_gap; tick |=> !tick [*3]; endproperty
    a_gap: assert property (p_gap) else $error("tick too soon");
    property p_halt; halt_r |-> !tick; endproperty
    a_halt: assert property (p_halt) else $error("tick while halted");
    property p_hole; req.rd && (req.addr == 4'h1 || req.addr > 4'h8)
        |=> rdata == 8'h00; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read");
    property p_hold; !req.rd |=> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_sec; rd2 |=> rdata[6:4] <= 3'h5 && rdata[3:0] <= 4'h9;
    endproperty
    a_sec: assert property (p_sec) else $error("seconds range");
    property p_min; rd3 |=> !rdata[7] && rdata[6:4] <= 3'h5; endproperty
    a_min: assert property (p_min) else $error("minutes range");
    property p_wday; rd6 |=> rdata[7:3] == 5'h00 && rdata[2:0] != 3'h7;
    endproperty
    a_wday: assert property (p_wday) else $error("weekday range");
endmodule : bcdtd_properties
`default_nettype wire

//--- sim/bcdtd_host_model.sv
// Host model that issues single register accesses to the counter bank.
// Assumes core_clk is the bank clock; requests move 1 ns after an edge.
`timescale 1ns/1ns
`default_nettype none
module bcdtd_host_model (
    input  wire logic                 core_clk,
    output var bcdtd_pkg::bcdtd_req_t req
);
    // Bus idles with no strobe raised.
    initial begin
        req = '{wr: 1'b0, rd: 1'b0, addr: 4'h0, wdata: 8'h00};
    end
    // Released lines are inverted so a stale value never looks valid.
    task automatic access(input logic w, input logic [3:0] a,
                          input logic [7:0] d);
        @(posedge core_clk);
        #1;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : bcdtd_host_model
`default_nettype wire

//--- sim/bcdtd_counters_test.sv
// Self-checking bench for the time and date counter bank.
// Assumes the host model drives all requests; ticks every 4 clocks.
`timescale 1ns/1ns
`default_nettype none
module bcdtd_counters_test;
    logic                  core_clk;
    logic                  sys_rst;
    bcdtd_pkg::bcdtd_req_t req;
    logic [7:0]            rdata;
    logic                  tick;
    logic                  hour_format_12;
    logic                  rd_prev;
    logic [7:0]            exp_q[$];
    int                    err_total;
    int                    checks;
    int                    cycles;
    logic [7:0]            ry;
    bcdtd_counters #(.TICK_CYCLES(4)) dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .req(req), .rdata(rdata), .tick(tick),
        .hour_format_12(hour_format_12));
    bcdtd_host_model host (.core_clk(core_clk), .req(req));
    // Free-running 100 MHz clock.
    always #5 core_clk = ~core_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd
    // Load a time, let exactly one tick through, then read everything.
    task automatic roll(input logic [7:0] f, h, d, mo, y, wd, eh, ed, em,
                        ey, ew);
        logic [7:0] v[7];
        int         n;
        v = '{8'h59, 8'h59, h, d, wd, mo, y};
        wr(4'h0, f | 8'h20);
        for (int i = 0; i < 7; i++) wr(4'(i + 2), v[i]);
        wr(4'h0, f);
        n = 0;
        while (tick !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        wr(4'h0, f | 8'h20);
        if (n == 40) err_total++;
        check({7'h0, hour_format_12}, {7'h0, f[2]});
        v = '{8'h00, 8'h00, eh, ed, ew, em, ey};
        for (int i = 0; i < 7; i++) rd(4'(i + 2), v[i]);
    endtask : roll
    // Data is registered at the read edge, so look half a cycle later.
    always @(posedge core_clk) rd_prev <= req.rd;
    always @(negedge core_clk) begin
        if (rd_prev === 1'b1) check(rdata, exp_q.pop_front());
    end
    // Hang guard well above the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    // Weekday codes are loaded freely; the bank only counts them.
    initial begin
        logic [7:0] rv[6];
        int         n;
        rv = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
        {core_clk, sys_rst, ry} = {2'b01, 8'h00};
        {cycles, err_total, checks} = '0;
        void'($urandom(85));
        repeat (12) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rd(4'h2, 8'h80);
        wr(4'h0, 8'h73);
        rd(4'h0, 8'h20);
        rd(4'h1, 8'h00);
        rd(4'hf, 8'h00);
        for (int i = 0; i < 6; i++) rd(4'(i + 3), rv[i]);
        rd(4'h2, 8'h81);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h00);
        roll(0, 8'h23, 8'h31, 8'h12, 8'h99, 6, 0, 1, 1, 0, 0);
        roll(0, 8'h23, 8'h28, 8'h02, 0, 2, 0, 8'h29, 2, 0, 3);
        roll(0, 8'h23, 8'h29, 8'h02, 4, 3, 0, 1, 3, 4, 4);
        roll(0, 8'h23, 8'h30, 8'h04, 8'h21, 5, 0, 1, 5, 8'h21, 6);
        roll(0, 8'h22, 8'h31, 1, 8'h21, 1, 8'h23, 8'h31, 1, 8'h21, 1);
        roll(4, 8'h11, 8'h15, 6, 0, 0, 8'h32, 8'h15, 6, 0, 0);
        roll(4, 8'h32, 8'h15, 6, 0, 0, 8'h21, 8'h15, 6, 0, 0);
        roll(4, 8'h31, 8'h31, 1, 0, 0, 8'h12, 1, 2, 0, 1);
        repeat (3) begin
            n = $urandom_range(99);
            ry = {4'(n / 10), 4'(n % 10)};
            roll(0, 8'h23, 8'h28, 2, ry, 2, 0, (n % 4 == 0) ? 8'h29 : 1,
                 (n % 4 == 0) ? 2 : 3, ry, 3);
        end
        repeat (4) @(posedge core_clk);
        report_and_stop();
    end
endmodule : bcdtd_counters_test
bind bcdtd_counters bcdtd_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .tick(tick), .hour_format_12(hour_format_12));
`default_nettype wire
